/* freq_measure_pkg.sv */
/*
 * shared constants for the frequency measurement counter channel.
 * assumes a 100 MHz system clock and a 32-bit apb register bus.
 */
package freq_measure_pkg;

    // word indices, then byte addresses at four bytes per word
    localparam logic [7:0]  board_control_off  = 8'h00;
    localparam logic [7:0]  irq_status_off     = 8'h02;
    localparam logic [7:0]  trigger_off        = 8'h04;
    localparam logic [7:0]  irq_status_addr    = {irq_status_off[5:0], 2'b00};
    localparam logic [7:0]  trigger_addr       = {trigger_off[5:0], 2'b00};
    localparam logic [7:0]  control_addr       = 8'h14;
    localparam logic [7:0]  constant_addr      = 8'h18;
    localparam logic [7:0]  readback_addr      = 8'h1c;
    localparam logic [7:0]  board_control_addr = {board_control_off[5:0], 2'b00};

    // control register fields
    localparam int          mode_lo_pos        = 0;
    localparam int          out_pol_pos        = 3;
    localparam int          gate_pol_pos       = 4;
    localparam int          meas_pol_pos       = 6;
    localparam int          trig_pol_pos       = 8;
    localparam int          mode_hi_pos        = 10;
    localparam int          debounce_pos       = 13;
    localparam int          unused_pos         = 14;
    localparam int          irq_en_pos         = 15;
    localparam logic [2:0]  mode_lo_freq       = 3'h4;
    localparam logic [2:0]  mode_hi_freq       = 3'h7;
    localparam logic [1:0]  pol_active_low     = 2'h1;
    localparam logic [1:0]  pol_active_high    = 2'h2;
    localparam logic [15:0] control_reset      = 16'h0000;
    localparam logic [15:0] control_wmask      = 16'hbfff;

    // timing
    localparam int          clk_period_ps      = 10000;
    localparam int          out_pulse_ps       = 1750000;
    localparam int          debounce_ps        = 2500000;
    localparam int          out_pulse_cycles   = out_pulse_ps / clk_period_ps;
    localparam int          debounce_cycles    = (debounce_ps + clk_period_ps - 1) / clk_period_ps + 1;

    typedef enum logic [1:0] {
        st_idle  = 2'b00,
        st_armed = 2'b01,
        st_count = 2'b10,
        st_done  = 2'b11
    } meas_state_t;

    // active edge or level decode of a two-bit polarity field
    function automatic logic pol_enabled(input logic [1:0] pol);
        pol_enabled = (pol == pol_active_low) || (pol == pol_active_high);
    endfunction : pol_enabled

    function automatic logic pol_active(input logic [1:0] pol, input logic lvl);
        pol_active = (pol == pol_active_high) ? lvl : ((pol == pol_active_low) ? ~lvl : 1'b0);
    endfunction : pol_active

endpackage : freq_measure_pkg

/* input_conditioner.sv */
/*
 * synchronises one field input and optionally filters short pulses.
 * assumes an asynchronous input pin and the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module input_conditioner #(
    parameter int FILTER_CYCLES = freq_measure_pkg::debounce_cycles
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin,
    input  wire logic filter_en,
    output logic      level
);
    import freq_measure_pkg::*;

    logic        sync1_reg, sync1_next;
    logic        sync2_reg, sync2_next;
    logic        level_reg, level_next;
    logic [15:0] cnt_reg,   cnt_next;

    always_comb begin
        sync1_next = pin;
        sync2_next = sync1_reg;
        level_next = level_reg;
        cnt_next   = 16'h0000;
        if (!filter_en) begin
            level_next = sync2_reg;
        end else if (sync2_reg != level_reg) begin
            // change accepted only after it outlasts the filter time
            if (cnt_reg >= 16'(FILTER_CYCLES - 1)) begin
                level_next = sync2_reg;
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            level_reg <= 1'b0;
            cnt_reg   <= 16'h0000;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            level_reg <= level_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign level = level_reg;

endmodule : input_conditioner
`default_nettype wire

/* pulse_stretcher.sv */
/*
 * drives a fixed-width pulse on the channel output pin.
 * assumes a one-cycle start strobe on the system clock.
 */
`timescale 1ns/10ps
`default_nettype none
module pulse_stretcher #(
    parameter int PULSE_CYCLES = freq_measure_pkg::out_pulse_cycles
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic active_high,
    output logic      pin_out,
    output logic      pin_oe
);
    import freq_measure_pkg::*;

    logic [15:0] cnt_reg, cnt_next;
    logic        out_reg, out_next;
    logic        oe_reg,  oe_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (start) begin
            cnt_next = 16'(PULSE_CYCLES);
        end else if (cnt_reg != 16'h0000) begin
            cnt_next = cnt_reg - 16'h0001;
        end
        oe_next  = (cnt_next != 16'h0000);
        // resting level is high, pullup behaviour
        out_next = oe_next ? active_high : 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
            out_reg <= 1'b1;
            oe_reg  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            oe_reg  <= oe_next;
        end
    end

    assign pin_out = out_reg;
    assign pin_oe  = oe_reg;

endmodule : pulse_stretcher
`default_nettype wire

/* frequency_measure_counter.sv */
/*
 * one counter channel in frequency-measurement mode with an apb slave.
 * assumes field inputs are asynchronous and the bus runs on clk.
 */
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module frequency_measure_counter #(
    parameter int COUNT_WIDTH     = 16,
    parameter int PULSE_CYCLES    = freq_measure_pkg::out_pulse_cycles,
    parameter int DEBOUNCE_CYCLES = freq_measure_pkg::debounce_cycles
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gate_input,
    input  wire logic        measured_signal_input,
    input  wire logic        trigger_input,
    output logic             counter_out,
    output logic             counter_out_oe,
    output logic             irq
);
    import freq_measure_pkg::*;

    logic                   gate_lvl;
    logic                   meas_lvl;
    logic                   trig_lvl;
    logic                   wr_en;
    logic                   rd_en;
    logic                   addr_ok;
    logic                   freq_mode;
    logic                   gate_act;
    logic                   meas_act;
    logic                   trig_act;
    logic                   trig_event;
    logic                   meas_edge;
    logic                   gate_rise;
    logic                   gate_fall;
    logic                   done_pulse;
    logic [1:0]             gate_pol;
    logic [1:0]             meas_pol;
    logic [1:0]             trig_pol;
    logic                   wr_trigger;
    logic                   wr_control;
    logic                   wr_constant;
    logic                   wr_board;
    logic                   wr_clear;

    logic [15:0]            control_reg,   control_next;
    logic [15:0]            constant_reg,  constant_next;
    logic                   board_reg,     board_next;
    logic [COUNT_WIDTH-1:0] count_reg,     count_next;
    logic                   pending_reg,   pending_next;
    logic                   gate_d_reg,    gate_d_next;
    logic                   meas_d_reg,    meas_d_next;
    logic                   trig_d_reg,    trig_d_next;
    logic [31:0]            rdata_reg,     rdata_next;
    logic                   err_reg,       err_next;
    meas_state_t            state_reg,     state_next;

    input_conditioner #(
        .FILTER_CYCLES (DEBOUNCE_CYCLES)
    ) u_gate_cond (
        .clk       (clk),
        .rst       (rst),
        .pin       (gate_input),
        .filter_en (control_reg[debounce_pos]),
        .level     (gate_lvl)
    );

    input_conditioner #(
        .FILTER_CYCLES (DEBOUNCE_CYCLES)
    ) u_meas_cond (
        .clk       (clk),
        .rst       (rst),
        .pin       (measured_signal_input),
        .filter_en (control_reg[debounce_pos]),
        .level     (meas_lvl)
    );

    input_conditioner #(
        .FILTER_CYCLES (DEBOUNCE_CYCLES)
    ) u_trig_cond (
        .clk       (clk),
        .rst       (rst),
        .pin       (trigger_input),
        .filter_en (control_reg[debounce_pos]),
        .level     (trig_lvl)
    );

    pulse_stretcher #(
        .PULSE_CYCLES (PULSE_CYCLES)
    ) u_out_pulse (
        .clk         (clk),
        .rst         (rst),
        .start       (done_pulse),
        .active_high (control_reg[out_pol_pos]),
        .pin_out     (counter_out),
        .pin_oe      (counter_out_oe)
    );

    // widen or cut a register word to the counter width
    function automatic logic [COUNT_WIDTH-1:0] fit_count(input logic [15:0] word);
        logic [COUNT_WIDTH+15:0] wide;
        wide      = {{COUNT_WIDTH{1'b0}}, word};
        fit_count = wide[COUNT_WIDTH-1:0];
    endfunction : fit_count

    // register words answer; all other addresses are refused
    function automatic logic addr_mapped(input logic [7:0] addr);
        case (addr)
            irq_status_addr, trigger_addr, control_addr,
            constant_addr, readback_addr, board_control_addr: addr_mapped = 1'b1;
            default:                                          addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    // apb decode, zero wait states
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !penable && !pwrite;
    assign addr_ok = addr_mapped(paddr);

    // one write strobe per writable register, access phase only
    assign wr_trigger  = wr_en && (paddr == trigger_addr);
    assign wr_control  = wr_en && (paddr == control_addr);
    assign wr_constant = wr_en && (paddr == constant_addr);
    assign wr_board    = wr_en && (paddr == board_control_addr);
    assign wr_clear    = wr_en && (paddr == irq_status_addr);

    // field decode
    assign gate_pol  = control_reg[gate_pol_pos +: 2];
    assign meas_pol  = control_reg[meas_pol_pos +: 2];
    assign trig_pol  = control_reg[trig_pol_pos +: 2];
    assign freq_mode = (control_reg[mode_lo_pos +: 3] == mode_lo_freq) &&
                       (control_reg[mode_hi_pos +: 3] == mode_hi_freq);

    assign gate_act = pol_active(gate_pol, gate_lvl);
    assign meas_act = pol_active(meas_pol, meas_lvl);
    assign trig_act = pol_active(trig_pol, trig_lvl);

    assign gate_rise = pol_enabled(gate_pol) && gate_act && !gate_d_reg;
    assign gate_fall = pol_enabled(gate_pol) && !gate_act && gate_d_reg;
    // only measured-signal edges advance the counter
    assign meas_edge = meas_act && !meas_d_reg;

    // external edge or software write to the trigger register
    assign trig_event = (trig_act && !trig_d_reg) ||
                        (wr_trigger && pwdata[0]);

    assign done_pulse = (state_reg == st_count) && gate_fall && freq_mode;

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        if (!freq_mode) begin
            state_next = st_idle;
        end else begin
            case (state_reg)
                st_idle, st_done: begin
                    if (trig_event) begin
                        state_next = st_armed;
                        count_next = '0;
                    end
                end
                st_armed: begin
                    if (gate_rise) begin
                        state_next = st_count;
                    end
                end
                st_count: begin
                    if (gate_fall) begin
                        state_next = st_done;
                    end else if (meas_edge) begin
                        count_next = count_reg + 1'b1;
                    end
                end
                default: begin
                    state_next = st_idle;
                end
            endcase
        end
        if (wr_constant && (state_reg == st_count)) begin
            count_next = fit_count(constant_next);
        end
    end

    always_comb begin
        control_next  = control_reg;
        constant_next = constant_reg;
        board_next    = board_reg;
        if (wr_control) begin
            control_next = pwdata[15:0] & control_wmask;
        end
        if (wr_constant) begin
            constant_next = pwdata[15:0];
        end
        if (wr_board) begin
            board_next = pwdata[0];
        end
    end

    always_comb begin
        pending_next = pending_reg;
        if (wr_clear && pwdata[0]) begin
            pending_next = 1'b0;
        end
        // a new event wins over a clear in the same cycle
        if (done_pulse && control_reg[irq_en_pos]) begin
            pending_next = 1'b1;
        end
        if (!control_next[irq_en_pos]) begin
            pending_next = 1'b0;
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                irq_status_addr:    rdata_next = {31'h0, pending_reg};
                control_addr:       rdata_next = {16'h0, control_reg};
                constant_addr:      rdata_next = {16'h0, constant_reg};
                readback_addr:      rdata_next = 32'(count_reg);
                board_control_addr: rdata_next = {31'h0, board_reg};
                default:            rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // refusal flag decided in the setup cycle, held through the access phase
    always_comb begin
        err_next = 1'b0;
        if (psel && !penable) begin
            err_next = !addr_ok;
        end else if (psel) begin
            err_next = err_reg;
        end
    end

    // level history for the edge detectors
    always_comb begin
        gate_d_next = gate_act;
        meas_d_next = meas_act;
        trig_d_next = trig_act;
    end

    // measurement state and counter
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= st_idle;
            count_reg <= '0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // software-visible registers
    always_ff @(posedge clk) begin
        if (rst) begin
            control_reg  <= control_reset;
            constant_reg <= 16'h0000;
            board_reg    <= 1'b0;
        end else begin
            control_reg  <= control_next;
            constant_reg <= constant_next;
            board_reg    <= board_next;
        end
    end

    // pending interrupt
    always_ff @(posedge clk) begin
        if (rst) begin
            pending_reg <= 1'b0;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // edge detector history
    always_ff @(posedge clk) begin
        if (rst) begin
            gate_d_reg <= 1'b0;
            meas_d_reg <= 1'b0;
            trig_d_reg <= 1'b0;
        end else begin
            gate_d_reg <= gate_d_next;
            meas_d_reg <= meas_d_next;
            trig_d_reg <= trig_d_next;
        end
    end

    // bus response
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= err_next;
        end
    end

    assign prdata  = rdata_reg;
    assign pready  = 1'b1;
    assign pslverr = err_reg && psel && penable;
    assign irq     = pending_reg;

endmodule : frequency_measure_counter
`default_nettype wire

/* freq_measure_props.sv */
/* port checker for the frequency counter channel.
   assumes bind into frequency_measure_counter, one clock. */
`timescale 1ns/10ps
`default_nettype none
module freq_measure_props
    import freq_measure_pkg::*;
#(
    parameter int PULSE_CYCLES = out_pulse_cycles
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gate_input,
    input wire logic        measured_signal_input,
    input wire logic        trigger_input,
    input wire logic        counter_out,
    input wire logic        counter_out_oe,
    input wire logic        irq
);
    logic        pol_reg, pol_next;
    logic [15:0] cnt_reg, cnt_next;
    wire acc     = psel && penable;
    wire wr_ctrl = acc && pwrite && paddr == control_addr;
    wire clr     = acc && pwrite && paddr == irq_status_addr && pwdata[0];
    wire mapped  = paddr inside {board_control_addr, irq_status_addr, trigger_addr,
                                 control_addr, constant_addr, readback_addr};

    // shadow of output polarity and length of the running pulse
    always_comb begin
        pol_next = wr_ctrl ? pwdata[3] : pol_reg;
        cnt_next = counter_out_oe ? cnt_reg + 16'h1 : 16'h0;
    end
    always_ff @(posedge clk) begin
        pol_reg <= rst ? 1'b0 : pol_next;
        cnt_reg <= rst ? 16'h0 : cnt_next;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_rest_high: assert property (!counter_out_oe |-> counter_out)
        else $error("output pin not high at rest");
    a_pulse_level: assert property (counter_out_oe |-> counter_out == pol_reg)
        else $error("output pulse has wrong level");
    a_pulse_len: assert property ($fell(counter_out_oe) |-> cnt_reg == PULSE_CYCLES)
        else $error("output pulse has wrong length");
    a_irq_source: assert property ($rose(irq) |-> counter_out_oe)
        else $error("interrupt raised without end of gate");
    a_irq_hold: assert property (irq && !clr && !(wr_ctrl && !pwdata[15]) |=> irq)
        else $error("pending interrupt dropped");
    a_irq_clear: assert property (clr |=> !irq || $rose(counter_out_oe))
        else $error("interrupt not cleared");
    a_irq_cancel: assert property (wr_ctrl && !pwdata[15] |=> !irq)
        else $error("interrupt not cancelled by enable clear");
    a_bit14_zero: assert property (acc && !pwrite && paddr == control_addr |->
        prdata[31:16] == 16'h0 && !prdata[14])
        else $error("unused control bits read nonzero");
    a_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr && pready)
        else $error("mapped access refused");

    cover property ($rose(counter_out_oe));
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule : freq_measure_props

bind frequency_measure_counter freq_measure_props #(.PULSE_CYCLES(PULSE_CYCLES)) i_freq_measure_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_input(gate_input),
    .measured_signal_input(measured_signal_input), .trigger_input(trigger_input),
    .counter_out(counter_out), .counter_out_oe(counter_out_oe), .irq(irq));
`default_nettype wire

/* field_source.sv */
/* field side model: gate, measured signal and trigger pins.
   assumes calls right after a rising clock edge. */
`timescale 1ns/10ps
`default_nettype none
module field_source (
    input  wire logic clk,
    output logic      gate,
    output logic      meas,
    output logic      trig
);
    initial begin
        gate = 1'b0;
        meas = 1'b0;
        trig = 1'b0;
    end
    task idle(input logic g, input logic m, input logic t);
        gate <= g;
        meas <= m;
        trig <= t;
        @(posedge clk);
    endtask : idle
    // gate held for a known number of cycles by the caller
    task set_gate(input logic lvl);
        gate <= lvl;
        @(posedge clk);
    endtask : set_gate
    task meas_pulse(input logic act, input int w, input int n);
        repeat (n) begin
            meas <= act;
            repeat (w) @(posedge clk);
            meas <= !act;
            repeat (w) @(posedge clk);
        end
    endtask : meas_pulse
    task trig_pulse(input logic act, input int w);
        trig <= act;
        repeat (w) @(posedge clk);
        trig <= !act;
        repeat (w) @(posedge clk);
    endtask : trig_pulse
endmodule : field_source
`default_nettype wire

/* tb_frequency_measure_counter.sv */
/* self-checking bench for the frequency counter channel.
   assumes the package, design, field model and checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_frequency_measure_counter;
    import freq_measure_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0;
    wire  logic [31:0] prdata;
    wire  logic  pready, pslverr, gate_input, measured_signal_input, trigger_input, counter_out, counter_out_oe, irq;
    int          num_errors = 0, samples_checked = 0;
    logic [31:0] exp_q[$];

    always #5 clk = ~clk;

    field_source i_field_source (.clk(clk), .gate(gate_input), .meas(measured_signal_input), .trig(trigger_input));
    frequency_measure_counter #(.COUNT_WIDTH(16), .PULSE_CYCLES(5), .DEBOUNCE_CYCLES(4)) i_frequency_measure_counter (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate_input(gate_input),
        .measured_signal_input(measured_signal_input), .trigger_input(trigger_input),
        .counter_out(counter_out), .counter_out_oe(counter_out_oe), .irq(irq));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task give_verdict;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        k = 0;
        while (pready !== 1'b1) begin
            k++;
            if (k > 20) begin
                num_errors++;
                give_verdict;
            end
            @(posedge clk);
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask : rd
    task wait_oe;
        int k;
        k = 0;
        while (counter_out_oe !== 1'b1) begin
            @(posedge clk);
            k++;
            if (k > 100) begin
                num_errors++;
                give_verdict;
            end
        end
    endtask : wait_oe

    always @(posedge clk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && exp_q.size() > 0)
            check(prdata, exp_q.pop_front());
    end

    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        give_verdict;
    end

    initial begin
        logic [1:0]  gp, mp, tp;
        logic        op;
        int          n;
        logic [15:0] v, cnt, ctl;
        void'($urandom(32'h0dcdd672));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(control_addr, 32'h0);
        apb(1'b1, control_addr, 32'hffff);
        rd(control_addr, 32'hbfff);
        rd(8'h20, 32'h0);
        apb(1'b1, board_control_addr, 32'h1);
        rd(board_control_addr, 32'h1);
        apb(1'b1, board_control_addr, 32'h0);
        for (int i = 0; i < 8; i++) begin
            gp = i[0] ? 2'h2 : 2'h1;
            mp = (i == 5) ? 2'h3 : (i[1] ? 2'h2 : 2'h1);
            tp = (i % 3 == 0) ? 2'h0 : ((i % 3 == 1) ? 2'h1 : 2'h2);
            op = 1'($urandom_range(1));
            n = $urandom_range(8, 1);
            v = (i == 3) ? 16'($urandom_range(4095, 1)) : 16'h0;
            ctl = {1'b1, 1'b0, 1'(i == 6), (i == 7) ? 3'h0 : 3'h7, tp, mp, gp, op, 3'h4};
            i_field_source.idle(gp == 2'h1, mp == 2'h1, tp == 2'h1);
            apb(1'b1, control_addr, {16'h0, ctl});
            repeat (10) @(posedge clk);
            if (tp == 2'h0) apb(1'b1, trigger_addr, 32'h1);
            else i_field_source.trig_pulse(tp == 2'h2, 12);
            i_field_source.meas_pulse(mp == 2'h2, 13, 2);
            repeat (6) @(posedge clk);
            if (i != 7) rd(readback_addr, 32'h0);
            i_field_source.set_gate(gp == 2'h2);
            repeat (12) @(posedge clk);
            if (v != 16'h0) apb(1'b1, constant_addr, {16'h0, v});
            i_field_source.meas_pulse(mp == 2'h2, (i == 6) ? 2 : 13, n);
            repeat (12) @(posedge clk);
            i_field_source.set_gate(gp != 2'h2);
            cnt = (i == 5 || i == 6) ? v : v + 16'(n);
            if (i == 7) begin
                repeat (40) @(posedge clk);
                check(32'(counter_out_oe | irq), 32'h0);
            end else begin
                wait_oe;
                check(32'(irq), 32'h1);
                @(posedge clk);
                check(32'(counter_out), 32'(op));
                i_field_source.meas_pulse(mp == 2'h2, 13, 2);
                rd(readback_addr, 32'(cnt));
                rd(irq_status_addr, 32'h1);
                if (i[0]) apb(1'b1, control_addr, {16'h0, ctl & 16'h7fff});
                else apb(1'b1, irq_status_addr, 32'h1);
                check(32'(irq), 32'h0);
            end
        end
        give_verdict;
    end
endmodule : tb_frequency_measure_counter
`default_nettype wire
